// ### common/dar_pkg.sv
`default_nettype none

package dar_pkg;

  // Register addresses as seen in the little-endian map.
  localparam logic [15:0] ADDR_STATE_FLAGS = 16'h03E9;
  localparam logic [15:0] ADDR_MODE_DISPLAY = 16'h03EA;
  localparam logic [15:0] ADDR_ACT_POS_LO = 16'h03EC;
  localparam logic [15:0] ADDR_ACT_POS_HI = 16'h03ED;
  localparam logic [15:0] ADDR_FAULT_SUMMARY = 16'h03EE;
  localparam logic [15:0] ADDR_FAULT_CODE = 16'h03EF;
  localparam logic [15:0] ADDR_IN_PINS_LO = 16'h03F0;
  localparam logic [15:0] ADDR_IN_PINS_HI = 16'h03F1;
  localparam logic [15:0] ADDR_OUT_PINS_LO = 16'h03F2;
  localparam logic [15:0] ADDR_OUT_PINS_HI = 16'h03F3;
  localparam logic [15:0] ADDR_PROBE_FALL_LO = 16'h03F6;
  localparam logic [15:0] ADDR_PROBE_FALL_HI = 16'h03F7;
  localparam logic [15:0] ADDR_PROBE_RISE_LO = 16'h03F8;
  localparam logic [15:0] ADDR_PROBE_RISE_HI = 16'h03F9;
  localparam logic [15:0] ADDR_PROBE_FLAGS = 16'h03FA;
  localparam logic [15:0] ADDR_ACT_SPEED_LO = 16'h03FC;
  localparam logic [15:0] ADDR_ACT_SPEED_HI = 16'h03FD;
  localparam logic [15:0] ADDR_COMMAND_FLAGS = 16'h0410;
  localparam logic [15:0] ADDR_REQ_MODE = 16'h0411;
  localparam logic [15:0] ADDR_GOAL_POS_LO = 16'h0412;
  localparam logic [15:0] ADDR_GOAL_POS_HI = 16'h0413;
  localparam logic [15:0] ADDR_CURRENT_RATIO = 16'h0438;
  localparam logic [15:0] ADDR_ENC_WINDOW = 16'h043C;
  localparam logic [15:0] ADDR_FOLLOW_REACTION = 16'h043D;
  localparam logic [15:0] ADDR_POS_ERR_RESET = 16'h043E;

  // Fault codes reported in the fault code register.
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_SHORT_GROUND = 16'h2130;
  localparam logic [15:0] CODE_SUPPLY_RANGE = 16'h5100;
  localparam logic [15:0] CODE_OVER_TEMP = 16'h4310;
  localparam logic [15:0] CODE_FOLLOW_ERR = 16'h8611;

  // Reset values and write limits of writable registers.
  localparam logic [15:0] COMMAND_RESET = 16'h0000;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] MODE_MIN = 16'h0000;
  localparam logic [15:0] MODE_MAX = 16'h0006;
  localparam logic [15:0] GOAL_RESET = 16'h0000;
  localparam logic [15:0] RATIO_RESET = 16'h0080;
  localparam logic [15:0] RATIO_MIN = 16'h0000;
  localparam logic [15:0] RATIO_MAX = 16'h00FF;
  localparam logic [15:0] WINDOW_RESET = 16'h0100;
  localparam logic [15:0] WINDOW_MIN = 16'h0000;
  localparam logic [15:0] WINDOW_MAX = 16'hFFFF;
  localparam logic [15:0] REACTION_RESET = 16'h0001;
  localparam logic [15:0] REACTION_MIN = 16'h0000;
  localparam logic [15:0] REACTION_MAX = 16'h0003;

  // Field positions.
  localparam int CMD_ENABLE_BIT = 3;
  localparam int CMD_FAULT_RESET_BIT = 7;
  localparam int STAT_ENABLED_BIT = 2;
  localparam int STAT_FAULT_BIT = 3;
  localparam int STAT_FOLLOW_BIT = 13;
  localparam int SUM_GENERIC_BIT = 0;
  localparam int SUM_CURRENT_BIT = 1;
  localparam int SUM_VOLTAGE_BIT = 2;
  localparam int SUM_TEMP_BIT = 3;
  localparam int SUM_FOLLOW_BIT = 5;

  typedef enum logic {
    DAR_ST_RUN,
    DAR_ST_FAULT
  } dar_state_t;

  typedef struct packed {
    logic short_to_ground;
    logic supply_out_of_range;
    logic over_temperature;
  } dar_fault_pins_t;

  typedef struct packed {
    logic [31:0] actual_position;
    logic [31:0] actual_speed;
    logic [31:0] probe_falling_pos;
    logic [31:0] probe_rising_pos;
    logic [31:0] output_pins;
    logic [15:0] probe_flags;
  } dar_meas_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dar_reg_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } dar_reg_rsp_t;

endpackage

`default_nettype wire

// ### core/dar_core.sv
// Summary of operation
// - A short to ground reports code 0x2130 and lights the high-voltage and fault lamps.
// - Supply out of range reports code 0x5100, high-voltage lamp dark and fault lamp lit.
// - A short, supply or heat fault enters Fault and forces the current command to zero.
// - After overheating the drive stays in Fault while the temperature is out of limits.
// - The following-error alarm clears only on a master write to register 1086.
// - Following-error detection and reaction use registers 1080, 1084 and 1085.
// - A 32-bit value uses two addresses, low half first; big-endian map swaps them.
// - The read-only mode display shows the active mode, 0 to 6, and resets to 0.
`default_nettype none

module dar_core (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic big_endian_map,
  input wire dar_pkg::dar_fault_pins_t fault_pins,
  input wire logic [31:0] input_pins,
  input wire dar_pkg::dar_meas_t meas,
  input wire logic [15:0] current_demand,
  input wire dar_pkg::dar_reg_req_t reg_req,
  output var dar_pkg::dar_reg_rsp_t reg_rsp,
  output logic [15:0] motor_current_cmd,
  output logic high_voltage_indicator,
  output logic fault_indicator
);

  // Pin synchronisers: fault pins, input pins and the endian strap.
  logic [35:0] pin_meta_r;
  logic [35:0] pin_sync_r;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pin_meta_r <= 36'h0;
      pin_sync_r <= 36'h0;
    end else begin
      pin_meta_r <= {big_endian_map, fault_pins, input_pins};
      pin_sync_r <= pin_meta_r;
    end
  end

  logic big_map;
  dar_pkg::dar_fault_pins_t pins;
  logic [31:0] in_pins;
  assign big_map = pin_sync_r[35];
  assign pins = pin_sync_r[34:32];
  assign in_pins = pin_sync_r[31:0];

  function automatic logic is_pair_addr(input logic [15:0] a);
    logic [15:0] base;
    base = {a[15:1], 1'b0};
    is_pair_addr = (base == dar_pkg::ADDR_ACT_POS_LO) || (base == dar_pkg::ADDR_IN_PINS_LO)
      || (base == dar_pkg::ADDR_OUT_PINS_LO) || (base == dar_pkg::ADDR_PROBE_FALL_LO)
      || (base == dar_pkg::ADDR_PROBE_RISE_LO) || (base == dar_pkg::ADDR_ACT_SPEED_LO)
      || (base == dar_pkg::ADDR_GOAL_POS_LO);
  endfunction

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // Register and control state.
  dar_pkg::dar_state_t state_r, state_nxt;
  logic [15:0] command_r, command_nxt;
  logic [15:0] req_mode_r, req_mode_nxt;
  logic [15:0] act_mode_r, act_mode_nxt;
  logic [31:0] goal_r, goal_nxt;
  logic [15:0] ratio_r, ratio_nxt;
  logic [15:0] window_r, window_nxt;
  logic [15:0] reaction_r, reaction_nxt;
  logic follow_r, follow_nxt;
  logic short_lat_r, short_lat_nxt;
  logic supply_lat_r, supply_lat_nxt;
  logic temp_lat_r, temp_lat_nxt;
  logic [15:0] code_r, code_nxt;
  logic [15:0] summary_r, summary_nxt;
  logic [15:0] current_r, current_nxt;
  dar_pkg::dar_reg_rsp_t rsp_r, rsp_nxt;

  logic [15:0] canon;
  logic wr_ok;
  logic [15:0] rd_val;
  logic rd_hit;
  logic [31:0] pos_err;
  logic [31:0] pos_err_abs;
  logic follow_detect;
  logic follow_trips;
  logic reset_req;
  logic leave_fault;
  logic [31:0] scaled;

  always_comb begin
    // Big-endian map swaps the halves of every 32-bit pair.
    // endian half swap
    canon = (big_map && is_pair_addr(reg_req.addr)) ? (reg_req.addr ^ 16'h0001) : reg_req.addr;

    // Writes outside a register's limits are refused and leave it untouched.
    // write range check
    unique case (canon)
      dar_pkg::ADDR_COMMAND_FLAGS: wr_ok = 1'b1;
      dar_pkg::ADDR_REQ_MODE: wr_ok = in_range(reg_req.wdata, dar_pkg::MODE_MIN,
                                               dar_pkg::MODE_MAX);
      dar_pkg::ADDR_GOAL_POS_LO: wr_ok = 1'b1;
      dar_pkg::ADDR_GOAL_POS_HI: wr_ok = 1'b1;
      dar_pkg::ADDR_CURRENT_RATIO: wr_ok = in_range(reg_req.wdata, dar_pkg::RATIO_MIN,
                                                    dar_pkg::RATIO_MAX);
      dar_pkg::ADDR_ENC_WINDOW: wr_ok = in_range(reg_req.wdata, dar_pkg::WINDOW_MIN,
                                                 dar_pkg::WINDOW_MAX);
      dar_pkg::ADDR_FOLLOW_REACTION: wr_ok = in_range(reg_req.wdata, dar_pkg::REACTION_MIN,
                                                      dar_pkg::REACTION_MAX);
      dar_pkg::ADDR_POS_ERR_RESET: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase

    rd_hit = 1'b1;
    unique case (canon)
      dar_pkg::ADDR_STATE_FLAGS: begin
        rd_val = 16'h0000;
        rd_val[dar_pkg::STAT_ENABLED_BIT] = (state_r == dar_pkg::DAR_ST_RUN)
          && command_r[dar_pkg::CMD_ENABLE_BIT];
        rd_val[dar_pkg::STAT_FAULT_BIT] = (state_r == dar_pkg::DAR_ST_FAULT);
        rd_val[dar_pkg::STAT_FOLLOW_BIT] = follow_r;
      end
      dar_pkg::ADDR_MODE_DISPLAY: rd_val = act_mode_r;
      dar_pkg::ADDR_ACT_POS_LO: rd_val = meas.actual_position[15:0];
      dar_pkg::ADDR_ACT_POS_HI: rd_val = meas.actual_position[31:16];
      dar_pkg::ADDR_FAULT_SUMMARY: rd_val = summary_r;
      dar_pkg::ADDR_FAULT_CODE: rd_val = code_r;
      dar_pkg::ADDR_IN_PINS_LO: rd_val = in_pins[15:0];
      dar_pkg::ADDR_IN_PINS_HI: rd_val = in_pins[31:16];
      dar_pkg::ADDR_OUT_PINS_LO: rd_val = meas.output_pins[15:0];
      dar_pkg::ADDR_OUT_PINS_HI: rd_val = meas.output_pins[31:16];
      dar_pkg::ADDR_PROBE_FALL_LO: rd_val = meas.probe_falling_pos[15:0];
      dar_pkg::ADDR_PROBE_FALL_HI: rd_val = meas.probe_falling_pos[31:16];
      dar_pkg::ADDR_PROBE_RISE_LO: rd_val = meas.probe_rising_pos[15:0];
      dar_pkg::ADDR_PROBE_RISE_HI: rd_val = meas.probe_rising_pos[31:16];
      dar_pkg::ADDR_PROBE_FLAGS: rd_val = meas.probe_flags;
      dar_pkg::ADDR_ACT_SPEED_LO: rd_val = meas.actual_speed[15:0];
      dar_pkg::ADDR_ACT_SPEED_HI: rd_val = meas.actual_speed[31:16];
      dar_pkg::ADDR_COMMAND_FLAGS: rd_val = command_r;
      dar_pkg::ADDR_REQ_MODE: rd_val = req_mode_r;
      dar_pkg::ADDR_GOAL_POS_LO: rd_val = goal_r[15:0];
      dar_pkg::ADDR_GOAL_POS_HI: rd_val = goal_r[31:16];
      dar_pkg::ADDR_CURRENT_RATIO: rd_val = ratio_r;
      dar_pkg::ADDR_ENC_WINDOW: rd_val = window_r;
      dar_pkg::ADDR_FOLLOW_REACTION: rd_val = reaction_r;
      dar_pkg::ADDR_POS_ERR_RESET: rd_val = 16'h0000;
      default: begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase

    // Register writes.
    command_nxt = command_r;
    req_mode_nxt = req_mode_r;
    goal_nxt = goal_r;
    ratio_nxt = ratio_r;
    window_nxt = window_r;
    reaction_nxt = reaction_r;
    if (reg_req.wr && wr_ok) begin
      unique case (canon)
        dar_pkg::ADDR_COMMAND_FLAGS: command_nxt = reg_req.wdata;
        dar_pkg::ADDR_REQ_MODE: req_mode_nxt = reg_req.wdata;
        dar_pkg::ADDR_GOAL_POS_LO: goal_nxt[15:0] = reg_req.wdata;
        dar_pkg::ADDR_GOAL_POS_HI: goal_nxt[31:16] = reg_req.wdata;
        dar_pkg::ADDR_CURRENT_RATIO: ratio_nxt = reg_req.wdata;
        dar_pkg::ADDR_ENC_WINDOW: window_nxt = reg_req.wdata;
        dar_pkg::ADDR_FOLLOW_REACTION: reaction_nxt = reg_req.wdata;
        default: ;
      endcase
    end

    // A ratio of zero switches the current off, so there is no following to check.
    // following error detection
    pos_err = goal_r - meas.actual_position;
    pos_err_abs = pos_err[31] ? (32'h0 - pos_err) : pos_err;
    follow_detect = (state_r == dar_pkg::DAR_ST_RUN) && (ratio_r != 16'h0000)
      && command_r[dar_pkg::CMD_ENABLE_BIT] && (pos_err_abs > {16'h0000, window_r});
    follow_trips = follow_r && (reaction_r != dar_pkg::REACTION_MIN);

    // Detection in the same cycle as the reset write keeps the alarm set.
    // alarm clear write
    follow_nxt = follow_detect || (follow_r
      && !(reg_req.wr && (canon == dar_pkg::ADDR_POS_ERR_RESET)));

    reset_req = reg_req.wr && wr_ok && (canon == dar_pkg::ADDR_COMMAND_FLAGS)
      && reg_req.wdata[dar_pkg::CMD_FAULT_RESET_BIT];

    // Fault is only left with every cause gone, so heat keeps the drive in Fault.
    // overheat holds fault
    leave_fault = (state_r == dar_pkg::DAR_ST_FAULT) && reset_req
      && !pins.short_to_ground && !pins.supply_out_of_range && !pins.over_temperature
      && !follow_trips;

    state_nxt = state_r;
    unique case (state_r)
      dar_pkg::DAR_ST_RUN: begin
        if (pins.short_to_ground || pins.supply_out_of_range || pins.over_temperature
            || (follow_detect && (reaction_r != dar_pkg::REACTION_MIN))) begin
          state_nxt = dar_pkg::DAR_ST_FAULT;
        end
      end
      dar_pkg::DAR_ST_FAULT: begin
        if (leave_fault) begin
          state_nxt = dar_pkg::DAR_ST_RUN;
        end
      end
    endcase

    short_lat_nxt = pins.short_to_ground || (short_lat_r && !leave_fault);
    supply_lat_nxt = pins.supply_out_of_range || (supply_lat_r && !leave_fault);
    temp_lat_nxt = pins.over_temperature || (temp_lat_r && !leave_fault);

    if (short_lat_nxt) begin
      code_nxt = dar_pkg::CODE_SHORT_GROUND;
    end else if (supply_lat_nxt) begin
      code_nxt = dar_pkg::CODE_SUPPLY_RANGE;
    end else if (temp_lat_nxt) begin
      code_nxt = dar_pkg::CODE_OVER_TEMP;
    end else if (follow_nxt) begin
      code_nxt = dar_pkg::CODE_FOLLOW_ERR;
    end else begin
      code_nxt = dar_pkg::CODE_NONE;
    end

    summary_nxt = 16'h0000;
    summary_nxt[dar_pkg::SUM_CURRENT_BIT] = short_lat_nxt;
    summary_nxt[dar_pkg::SUM_VOLTAGE_BIT] = supply_lat_nxt;
    summary_nxt[dar_pkg::SUM_TEMP_BIT] = temp_lat_nxt;
    summary_nxt[dar_pkg::SUM_FOLLOW_BIT] = follow_nxt;
    summary_nxt[dar_pkg::SUM_GENERIC_BIT] = short_lat_nxt || supply_lat_nxt || temp_lat_nxt
      || follow_nxt;

    act_mode_nxt = (state_nxt == dar_pkg::DAR_ST_RUN) ? req_mode_nxt : act_mode_r;

    // Current ratio scales demand in 1/256 steps of full scale.
    // zero current in fault
    scaled = {16'h0000, current_demand} * {16'h0000, ratio_r};
    if ((state_nxt == dar_pkg::DAR_ST_FAULT) || !command_r[dar_pkg::CMD_ENABLE_BIT]) begin
      current_nxt = 16'h0000;
    end else begin
      current_nxt = scaled[23:8];
    end

    rsp_nxt.ack = reg_req.rd || reg_req.wr;
    rsp_nxt.err = (reg_req.wr && !wr_ok) || (reg_req.rd && !reg_req.wr && !rd_hit);
    rsp_nxt.rdata = (reg_req.rd && !reg_req.wr) ? rd_val : 16'h0000;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r <= dar_pkg::DAR_ST_RUN;
      command_r <= dar_pkg::COMMAND_RESET;
      req_mode_r <= dar_pkg::MODE_RESET;
      act_mode_r <= dar_pkg::MODE_RESET;
      goal_r <= {dar_pkg::GOAL_RESET, dar_pkg::GOAL_RESET};
      ratio_r <= dar_pkg::RATIO_RESET;
      window_r <= dar_pkg::WINDOW_RESET;
      reaction_r <= dar_pkg::REACTION_RESET;
      follow_r <= 1'b0;
      short_lat_r <= 1'b0;
      supply_lat_r <= 1'b0;
      temp_lat_r <= 1'b0;
      code_r <= dar_pkg::CODE_NONE;
      summary_r <= 16'h0000;
      current_r <= 16'h0000;
      rsp_r <= '0;
    end else begin
      state_r <= state_nxt;
      command_r <= command_nxt;
      req_mode_r <= req_mode_nxt;
      act_mode_r <= act_mode_nxt;
      goal_r <= goal_nxt;
      ratio_r <= ratio_nxt;
      window_r <= window_nxt;
      reaction_r <= reaction_nxt;
      follow_r <= follow_nxt;
      short_lat_r <= short_lat_nxt;
      supply_lat_r <= supply_lat_nxt;
      temp_lat_r <= temp_lat_nxt;
      code_r <= code_nxt;
      summary_r <= summary_nxt;
      current_r <= current_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  assign reg_rsp = rsp_r;
  assign motor_current_cmd = current_r;
  assign high_voltage_indicator = short_lat_r;
  assign fault_indicator = (state_r == dar_pkg::DAR_ST_FAULT) || short_lat_r || supply_lat_r
    || temp_lat_r;

endmodule // dar_core

`default_nettype wire

// ### sim/dar_core_properties.sv
`default_nettype none

module dar_core_properties (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic big_endian_map,
  input wire dar_pkg::dar_fault_pins_t fault_pins,
  input wire logic [31:0] input_pins,
  input wire dar_pkg::dar_meas_t meas,
  input wire logic [15:0] current_demand,
  input wire dar_pkg::dar_reg_req_t reg_req,
  input wire dar_pkg::dar_reg_rsp_t reg_rsp,
  input wire logic [15:0] motor_current_cmd,
  input wire logic high_voltage_indicator,
  input wire logic fault_indicator
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  lamp_pair_a: assert property (
    high_voltage_indicator |-> fault_indicator && motor_current_cmd == 16'h0000)
    else $error("high-voltage lamp lit without fault");
  short_trip_a: assert property (
    fault_pins.short_to_ground [*3] |=> high_voltage_indicator && fault_indicator
    && motor_current_cmd == 16'h0000) else $error("short fault not reported");
  supply_trip_a: assert property (
    fault_pins.supply_out_of_range [*3] |=> fault_indicator && motor_current_cmd == 16'h0000)
    else $error("supply fault not reported");
  temp_trip_a: assert property (
    fault_pins.over_temperature [*3] |=> fault_indicator && motor_current_cmd == 16'h0000)
    else $error("overheat fault not reported");
  temp_holds_a: assert property (
    $past(fault_pins.over_temperature, 2) && fault_indicator |=> fault_indicator)
    else $error("fault left while hot");
  mode_range_a: assert property (
    reg_req.wr && reg_req.addr == dar_pkg::ADDR_REQ_MODE && reg_req.wdata > dar_pkg::MODE_MAX
    |=> reg_rsp.ack && reg_rsp.err) else $error("mode out of range accepted");
  mode_display_a: assert property (
    reg_req.rd && !reg_req.wr && reg_req.addr == dar_pkg::ADDR_MODE_DISPLAY
    |=> reg_rsp.ack && !reg_rsp.err && reg_rsp.rdata <= dar_pkg::MODE_MAX)
    else $error("mode display out of range");
  pos_little_a: assert property (
    (!big_endian_map) [*3] ##0
    (reg_req.rd && !reg_req.wr && reg_req.addr == dar_pkg::ADDR_ACT_POS_LO)
    |=> reg_rsp.rdata == $past(meas.actual_position[15:0])) else $error("little map half wrong");
  pos_big_a: assert property (
    big_endian_map [*3] ##0 (reg_req.rd && !reg_req.wr && reg_req.addr == dar_pkg::ADDR_ACT_POS_LO)
    |=> reg_rsp.rdata == $past(meas.actual_position[31:16])) else $error("big map half wrong");
  err_reset_a: assert property (
    reg_req.wr && reg_req.addr == dar_pkg::ADDR_POS_ERR_RESET |=> reg_rsp.ack && !reg_rsp.err)
    else $error("error reset write refused");
endmodule // dar_core_properties

`default_nettype wire

// ### sim/dar_master.sv
`default_nettype none

module dar_master (
  input wire logic sys_clk,
  input wire dar_pkg::dar_reg_rsp_t reg_rsp,
  output var dar_pkg::dar_reg_req_t reg_req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial reg_req = '0;

  // The strobe is one cycle wide; the answer is taken one cycle later, as the strobe is released.
  // Released address and data are inverted so that no stale value looks valid.
  task automatic xfer(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
                      output logic [15:0] rdata, output logic err);
    @(posedge sys_clk);
    #1;
    reg_req = '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
    @(posedge sys_clk);
    #1;
    reg_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
    rdata = reg_rsp.rdata;
    err = reg_rsp.ack ? reg_rsp.err : 1'b1;
  endtask
endmodule // dar_master

`default_nettype wire

// ### sim/tb_top.sv
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic big_endian_map = 1'b0;
  dar_pkg::dar_fault_pins_t fault_pins = '0;
  logic [31:0] input_pins = 32'h0000_0000;
  dar_pkg::dar_meas_t meas = '0;
  logic [15:0] current_demand = 16'h0000;
  dar_pkg::dar_reg_req_t reg_req;
  dar_pkg::dar_reg_rsp_t reg_rsp;
  logic [15:0] motor_current_cmd;
  logic high_voltage_indicator;
  logic fault_indicator;
  int errors = 0;
  int cmp_count = 0;
  int seed = 89212;
  logic [15:0] rd_v;
  logic rd_e;
  logic [15:0] v;

  always #10 sys_clk = ~sys_clk;

  dar_core dut_u (.sys_clk(sys_clk), .resetn(resetn), .big_endian_map(big_endian_map),
    .fault_pins(fault_pins), .input_pins(input_pins), .meas(meas),
    .current_demand(current_demand), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .motor_current_cmd(motor_current_cmd), .high_voltage_indicator(high_voltage_indicator),
    .fault_indicator(fault_indicator));
  dar_master master_u (.sys_clk(sys_clk), .reg_rsp(reg_rsp), .reg_req(reg_req));

  function automatic logic [15:0] half(input logic [31:0] w, input logic hi);
    return hi ? w[31:16] : w[15:0];
  endfunction

  function automatic logic [15:0] exp_cur(input logic [15:0] d, input logic [15:0] r);
    return 16'((32'(d) * 32'(r)) >> 8);
  endfunction

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic e);
    master_u.xfer(1'b1, a, d, rd_v, rd_e);
    chk("write refusal", {15'h0000, rd_e}, {15'h0000, e});
  endtask

  // A refused read shows as a mismatch through the marker value.
  task automatic rd(input string n, input logic [15:0] a, input logic [15:0] x);
    master_u.xfer(1'b0, a, 16'h0000, rd_v, rd_e);
    chk(n, rd_e ? 16'hEEEE : rd_v, x);
  endtask

  task automatic flag(input string n, input int b, input logic e);
    master_u.xfer(1'b0, dar_pkg::ADDR_STATE_FLAGS, 16'h0000, rd_v, rd_e);
    chk(n, {15'h0000, rd_v[b]}, {15'h0000, e});
  endtask

  task automatic do_reset();
    resetn = 1'b0;
    fault_pins = '0;
    cyc(2);
    resetn = 1'b1;
  endtask

  task automatic conclude();
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    rd("ratio", dar_pkg::ADDR_CURRENT_RATIO, dar_pkg::RATIO_RESET);
    rd("window", dar_pkg::ADDR_ENC_WINDOW, dar_pkg::WINDOW_RESET);
    rd("reaction", dar_pkg::ADDR_FOLLOW_REACTION, dar_pkg::REACTION_RESET);
    rd("display", dar_pkg::ADDR_MODE_DISPLAY, dar_pkg::MODE_RESET);
    for (int i = 0; i < 9; i++) begin
      v = (i < 8) ? 16'(i) : 16'($random(seed)) | 16'h0100;
      wr(dar_pkg::ADDR_REQ_MODE, v, v > 16'h0006);
      rd("display", dar_pkg::ADDR_MODE_DISPLAY, (v > 16'h0006) ? 16'h0006 : v);
    end
    wr(dar_pkg::ADDR_FAULT_CODE, 16'h1234, 1'b1);
    rd("code", dar_pkg::ADDR_FAULT_CODE, dar_pkg::CODE_NONE);
    master_u.xfer(1'b0, 16'h0400, 16'h0000, rd_v, rd_e);
    chk("unmapped", {rd_e, rd_v[14:0]}, 16'h8000);
    for (int m = 0; m < 2; m++) begin
      big_endian_map = m[0];
      meas = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed), 16'h0000};
      input_pins = $random(seed);
      cyc(3);
      rd("pos lo", dar_pkg::ADDR_ACT_POS_LO, half(meas.actual_position, m[0]));
      rd("pos hi", dar_pkg::ADDR_ACT_POS_HI, half(meas.actual_position, !m[0]));
      rd("speed lo", dar_pkg::ADDR_ACT_SPEED_LO, half(meas.actual_speed, m[0]));
      rd("pins hi", dar_pkg::ADDR_IN_PINS_HI, half(input_pins, !m[0]));
    end
    big_endian_map = 1'b0;
    meas.actual_position = 32'h0000_0000;
    wr(dar_pkg::ADDR_COMMAND_FLAGS, 16'h0008, 1'b0);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 16'h0000 : (i == 1) ? 16'h00FF : 16'($random(seed) & 255) | 16'h0001;
      current_demand = 16'($random(seed));
      wr(dar_pkg::ADDR_CURRENT_RATIO, v, 1'b0);
      cyc(2);
      chk("current", motor_current_cmd, exp_cur(current_demand, v));
    end
    wr(dar_pkg::ADDR_CURRENT_RATIO, 16'h0100, 1'b1);
    // Reaction 0 raises the alarm only, so the current keeps flowing.
    wr(dar_pkg::ADDR_FOLLOW_REACTION, 16'h0000, 1'b0);
    wr(dar_pkg::ADDR_GOAL_POS_LO, 16'h0101, 1'b0);
    cyc(2);
    rd("code", dar_pkg::ADDR_FAULT_CODE, dar_pkg::CODE_FOLLOW_ERR);
    chk("current", motor_current_cmd, exp_cur(current_demand, v));
    wr(dar_pkg::ADDR_GOAL_POS_LO, 16'h0100, 1'b0);
    cyc(2);
    flag("alarm kept", dar_pkg::STAT_FOLLOW_BIT, 1'b1);
    wr(dar_pkg::ADDR_POS_ERR_RESET, 16'h0000, 1'b0);
    flag("alarm cleared", dar_pkg::STAT_FOLLOW_BIT, 1'b0);
    wr(dar_pkg::ADDR_FOLLOW_REACTION, 16'h0004, 1'b1);
    wr(dar_pkg::ADDR_FOLLOW_REACTION, 16'h0003, 1'b0);
    wr(dar_pkg::ADDR_GOAL_POS_LO, 16'h0101, 1'b0);
    cyc(2);
    chk("trip current", motor_current_cmd, 16'h0000);
    flag("trip state", dar_pkg::STAT_FAULT_BIT, 1'b1);
    for (int k = 0; k < 3; k++) begin
      do_reset();
      wr(dar_pkg::ADDR_COMMAND_FLAGS, 16'h0008, 1'b0);
      current_demand = 16'h1000;
      fault_pins = 3'(4 >> k);
      cyc(4);
      chk("high voltage lamp", {15'h0000, high_voltage_indicator}, {15'h0000, k == 0});
      chk("fault lamp", {15'h0000, fault_indicator}, 16'h0001);
      chk("current", motor_current_cmd, 16'h0000);
      rd("code", dar_pkg::ADDR_FAULT_CODE, (k == 0) ? dar_pkg::CODE_SHORT_GROUND :
        (k == 1) ? dar_pkg::CODE_SUPPLY_RANGE : dar_pkg::CODE_OVER_TEMP);
      wr(dar_pkg::ADDR_COMMAND_FLAGS, 16'h0080, 1'b0);
      cyc(2);
      chk("fault held", {15'h0000, fault_indicator}, 16'h0001);
      fault_pins = '0;
      cyc(3);
      wr(dar_pkg::ADDR_COMMAND_FLAGS, 16'h0080, 1'b0);
      rd("code", dar_pkg::ADDR_FAULT_CODE, dar_pkg::CODE_NONE);
      chk("high voltage lamp off", {15'h0000, high_voltage_indicator}, 16'h0000);
      chk("fault lamp off", {15'h0000, fault_indicator}, 16'h0000);
    end
    conclude();
  end

  initial begin
    #200000;
    errors++;
    conclude();
  end
endmodule // tb_top

bind dar_core dar_core_properties chk_u (.sys_clk(sys_clk), .resetn(resetn),
  .big_endian_map(big_endian_map), .fault_pins(fault_pins), .input_pins(input_pins),
  .meas(meas), .current_demand(current_demand), .reg_req(reg_req), .reg_rsp(reg_rsp),
  .motor_current_cmd(motor_current_cmd), .high_voltage_indicator(high_voltage_indicator),
  .fault_indicator(fault_indicator));

`default_nettype wire
